// ===== design/ddrb_port.sv
// Double-rate SRAM port: command decode, write capture, read pipeline, echo
//
// Overview of operation
// - Address taken on positive clock rise; one burst
// - Write words taken on positive then negative rise
// - Read words driven on both clock rises
// - Two words per location, sequential burst order
// - PLL enabled: read latency two and half
// - PLL disabled: read latency one cycle
// - Read-valid flag leads read data by half a cycle
// - Complementary echo clocks aligned to read data
// - Shared data pins; never both drive
// - Inputs synchronised on clk, taken at input clock rises
// - Data outputs launched from output flip-flops
// - Array write self-timed after burst captured
// - Only rising edges of input clocks matter
// - Byte selects masked per data word
`timescale 1ns/100ps
`default_nettype none

module ddrb_port
    import ddrb_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    ce,
    input  wire logic                    k,
    input  wire logic                    k_n,
    input  wire logic                    load_n,
    input  wire logic                    rd_wr,
    input  wire logic [`DDRB_ADDR_W-1:0] addr,
    input  wire logic [`DDRB_WORD_W-1:0] dq_in,
    output var  logic [`DDRB_WORD_W-1:0] dq_out,
    output var  logic                    dq_oe,
    input  wire logic [`DDRB_BYTES-1:0]  byte_write_sel_n,
    input  wire logic                    pll_off_n,
    output var  logic                    echo_clock,
    output var  logic                    echo_clock_n,
    output var  logic                    read_valid_flag
);
    localparam int SW = 5 + `DDRB_ADDR_W + `DDRB_WORD_W + `DDRB_BYTES;

    function automatic logic rose(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    ddrb_arr_if arr ();

    logic [SW-1:0] pin_s1_q;
    logic [SW-1:0] pin_s2_q;
    logic          k_s;
    logic          kn_s;
    logic          load_n_s;
    logic          rd_wr_s;
    logic          pll_on_s;
    ddrb_addr_t    addr_s;
    ddrb_word_t    dq_s;
    ddrb_be_t      bws_n_s;
    logic          k_prev_q;
    logic          kn_prev_q;
    logic          k_rise;
    logic          kn_rise;
    logic          hedge;
    logic          cmd_rd;
    logic          cmd_wr;
    logic [2:0]    ins_idx;
    logic [`DDRB_PIPE_W-1:0] rdv_q;
    ddrb_addr_t    rda_q [`DDRB_PIPE_W];
    ddrb_out_e     out_state_q;
    ddrb_word_t    word1_q;
    logic          wr_pend_q;
    ddrb_addr_t    wr_addr_q;
    logic          wb_act_q;
    ddrb_addr_t    wb_addr_q;
    ddrb_word_t    w0_q;
    ddrb_be_t      be0_q;
    logic          wr_en_q;
    ddrb_addr_t    wr_line_addr_q;
    ddrb_line_t    wr_data_q;
    ddrb_lbe_t     wr_be_q;

    // Two-stage synchroniser on every pin; second stage alone feeds logic
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else if (ce)
        begin
            pin_s1_q <= {k, k_n, load_n, rd_wr, pll_off_n, addr, dq_in,
                         byte_write_sel_n};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign {k_s, kn_s, load_n_s, rd_wr_s, pll_on_s, addr_s, dq_s, bws_n_s} = pin_s2_q;

    // Edge memory for both input clocks
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            k_prev_q  <= 1'b0;
            kn_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            k_prev_q  <= k_s;
            kn_prev_q <= kn_s;
        end
    end

    assign k_rise  = rose(k_s, k_prev_q);
    assign kn_rise = rose(kn_s, kn_prev_q);
    assign hedge   = k_rise | kn_rise;

    // decode only from registered inputs at a clock rise
    assign cmd_rd  = k_rise & ~load_n_s & rd_wr_s;
    assign cmd_wr  = k_rise & ~load_n_s & ~rd_wr_s;
    // latency chosen per command; mode change mid-stream is not smoothed
    assign ins_idx = pll_on_s ? `DDRB_LAT_PLL_HALF - 3'h1 : `DDRB_LAT_BYP_HALF - 3'h1;

    // each read command enters the half-cycle pipeline once
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdv_q <= '0;
        end
        else if (ce && hedge)
        begin
            for (int i = 0; i < `DDRB_PIPE_W - 1; i++)
            begin
                rdv_q[i] <= rdv_q[i+1];
                rda_q[i] <= rda_q[i+1];
            end
            rdv_q[`DDRB_PIPE_W-1] <= 1'b0;
            if (cmd_rd)
            begin
                rdv_q[ins_idx] <= 1'b1;
                rda_q[ins_idx] <= addr_s;
            end
        end
    end

    // Array is read at launch time, so a just-written line is current
    assign arr.rd_addr = rda_q[0];

    // word 0 then word 1 on successive rises of either clock
    // pins driven straight from these flops
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_state_q <= DDRB_OUT_IDLE;
            dq_out      <= '0;
            dq_oe       <= 1'b0;
            word1_q     <= '0;
        end
        else if (ce && hedge)
        begin
            if (rdv_q[0])
            begin
                // low half of the line goes first
                dq_out      <= arr.rd_data[`DDRB_WORD_W-1:0];
                word1_q     <= arr.rd_data[2*`DDRB_WORD_W-1:`DDRB_WORD_W];
                dq_oe       <= 1'b1;
                out_state_q <= DDRB_OUT_WORD0;
            end
            else
            begin
                case (out_state_q)
                    DDRB_OUT_WORD0:
                    begin
                        dq_out      <= word1_q;
                        dq_oe       <= 1'b1;
                        out_state_q <= DDRB_OUT_WORD1;
                    end
                    default:
                    begin
                        // release the shared pins once the burst ends
                        dq_oe       <= 1'b0;
                        out_state_q <= DDRB_OUT_IDLE;
                    end
                endcase
            end
        end
    end

    // flag rises half a cycle ahead of word 0
    always_ff @(posedge clk)
    begin
        if (srst)
            read_valid_flag <= 1'b0;
        else if (ce && hedge)
            read_valid_flag <= rdv_q[1] | rdv_q[0];
    end

    // free-running echoes, same register delay as the data pins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            echo_clock   <= 1'b0;
            echo_clock_n <= 1'b0;
        end
        else if (ce)
        begin
            echo_clock   <= k_s;
            echo_clock_n <= kn_s;
        end
    end

    // word 0 on the positive rise after the write command
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_pend_q <= 1'b0;
            wb_act_q  <= 1'b0;
            wr_addr_q <= '0;
            wb_addr_q <= '0;
            w0_q      <= '0;
            be0_q     <= '0;
        end
        else if (ce)
        begin
            if (k_rise)
            begin
                wr_pend_q <= cmd_wr;
                if (cmd_wr)
                    wr_addr_q <= addr_s;
                if (wr_pend_q)
                begin
                    wb_act_q  <= 1'b1;
                    wb_addr_q <= wr_addr_q;
                    w0_q      <= dq_s;
                    be0_q     <= ~bws_n_s;  // selects ride with word 0
                end
            end
            else if (kn_rise && wb_act_q)
                wb_act_q <= 1'b0;
        end
    end

    // one internal write pulse once word 1 lands, host times nothing
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_en_q        <= 1'b0;
            wr_line_addr_q <= '0;
            wr_data_q      <= '0;
            wr_be_q        <= '0;
        end
        else if (ce)
        begin
            wr_en_q <= kn_rise & wb_act_q;
            if (kn_rise && wb_act_q)
            begin
                wr_line_addr_q <= wb_addr_q;
                wr_data_q      <= {dq_s, w0_q};
                // unselected bytes keep their stored value
                wr_be_q        <= {~bws_n_s, be0_q};
            end
        end
    end

    assign arr.wr_en   = wr_en_q;
    assign arr.wr_addr = wr_line_addr_q;
    assign arr.wr_data = wr_data_q;
    assign arr.wr_be   = wr_be_q;

    ddrb_array u_array (
        .clk (clk),
        .ce  (ce),
        .arr (arr.mem)
    );

    // Checks; bursts assume at least four clk cycles per half input period
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || !ce);

    sequence s_word0_launch;
        hedge && rdv_q[0];
    endsequence
    sequence s_two_words;
        dq_oe[*7];
    endsequence

    property p_lat_pll;
        cmd_rd && pll_on_s |=> rdv_q[4] && rda_q[4] == $past(addr_s);
    endproperty
    a_lat_pll: assert property (p_lat_pll) else $error("read latency wrong, pll on");

    property p_lat_byp;
        cmd_rd && !pll_on_s |=> rdv_q[1] && !rdv_q[4];
    endproperty
    a_lat_byp: assert property (p_lat_byp) else $error("read latency wrong, pll off");

    property p_burst;
        s_word0_launch |=> s_two_words;
    endproperty
    a_burst: assert property (p_burst) else $error("burst not two words long");

    property p_valid_lead;
        s_word0_launch |-> read_valid_flag;
    endproperty
    a_valid_lead: assert property (p_valid_lead) else $error("valid not ahead of data");

    property p_echo;
        k_rise |=> echo_clock;
    endproperty
    a_echo: assert property (p_echo) else $error("echo clock not following input");

    property p_no_drive_wr;
        k_rise && wr_pend_q |-> !dq_oe;
    endproperty
    a_no_drive_wr: assert property (p_no_drive_wr) else $error("driving during write data");

    property p_rise_only;
        !hedge |=> $stable(dq_out) && $stable(dq_oe);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("output moved off a rise");

    property p_self_timed;
        arr.wr_en |=> !arr.wr_en;
    endproperty
    a_self_timed: assert property (p_self_timed) else $error("array write not one pulse");

    property p_wr_word1;
        kn_rise && wb_act_q |=> arr.wr_en
            && arr.wr_data[2*`DDRB_WORD_W-1:`DDRB_WORD_W] == $past(dq_s);
    endproperty
    a_wr_word1: assert property (p_wr_word1) else $error("write word 1 not taken");
endmodule

`default_nettype wire

// ===== design/ddrb_defs.svh
// Constants for the two-word burst double-rate SRAM port
`ifndef DDRB_DEFS_SVH
`define DDRB_DEFS_SVH

`define DDRB_WORD_W        18
`define DDRB_BYTE_W        9
`define DDRB_BYTES         2
`define DDRB_ADDR_W        4
`define DDRB_DEPTH         16
`define DDRB_PIPE_W        5
`define DDRB_LAT_PLL_HALF  3'h5
`define DDRB_LAT_BYP_HALF  3'h2

`endif

// ===== design/ddrb_pkg.sv
// Types shared by the SRAM port and its storage array
`include "ddrb_defs.svh"

package ddrb_pkg;
    typedef logic [`DDRB_WORD_W-1:0]   ddrb_word_t;
    typedef logic [2*`DDRB_WORD_W-1:0] ddrb_line_t;
    typedef logic [`DDRB_ADDR_W-1:0]   ddrb_addr_t;
    typedef logic [`DDRB_BYTES-1:0]    ddrb_be_t;
    typedef logic [2*`DDRB_BYTES-1:0]  ddrb_lbe_t;

    typedef enum logic [1:0] {
        DDRB_OUT_IDLE  = 2'b00,
        DDRB_OUT_WORD0 = 2'b01,
        DDRB_OUT_WORD1 = 2'b10
    } ddrb_out_e;
endpackage

// ===== design/ddrb_arr_if.sv
// Write and read channel between the port logic and the storage array
`timescale 1ns/100ps
`default_nettype none

interface ddrb_arr_if;
    import ddrb_pkg::*;
    logic       wr_en;
    ddrb_addr_t wr_addr;
    ddrb_line_t wr_data;
    ddrb_lbe_t  wr_be;
    ddrb_addr_t rd_addr;
    ddrb_line_t rd_data;

    modport ctl (output wr_en, output wr_addr, output wr_data, output wr_be,
                 output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input wr_be,
                 input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ===== design/ddrb_array.sv
// Flip-flop storage array, two words per location, byte-maskable writes
`timescale 1ns/100ps
`default_nettype none

module ddrb_array
    import ddrb_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   ce,
    ddrb_arr_if.mem     arr
);
    wire ddrb_line_t rd_line;

    // One lane per byte, each with its own storage so no flop has two writers
    for (genvar g = 0; g < 2*`DDRB_BYTES; g++)
    begin : g_lane
        logic [`DDRB_BYTE_W-1:0] lane_q [`DDRB_DEPTH];

        // Data storage needs no reset
        always_ff @(posedge clk)
        begin
            if (ce && arr.wr_en && arr.wr_be[g])
            begin
                lane_q[arr.wr_addr] <= arr.wr_data[g*`DDRB_BYTE_W +: `DDRB_BYTE_W];
            end
        end

        // Read is combinational so a launch sees the latest completed write
        assign rd_line[g*`DDRB_BYTE_W +: `DDRB_BYTE_W] = lane_q[arr.rd_addr];
    end

    assign arr.rd_data = rd_line;
endmodule

`default_nettype wire

// ===== verif/ddrb_host_model.sv
// Host controller model: link clocks, commands, write data, read capture
`timescale 1ns/100ps
`default_nettype none

module ddrb_host_model
    import ddrb_pkg::*;
(
    output var  logic       k,
    output var  logic       k_n,
    output var  logic       load_n,
    output var  logic       rd_wr,
    output var  ddrb_addr_t addr,
    output var  ddrb_word_t dq_drv,
    output var  logic       host_oe,
    output var  ddrb_be_t   sel_n,
    input  wire ddrb_word_t dq_out,
    input  wire logic       dq_oe,
    input  wire logic       read_valid_flag,
    input  wire logic       echo_clock,
    input  wire logic       echo_clock_n
);
    // complementary pair, free running
    // Odd start offset keeps the pair out of phase with clk
    initial
    begin
        k = 1'b0;
        k_n = 1'b1;
        load_n = 1'b1;
        rd_wr = 1'b0;
        addr = 4'h0;
        dq_drv = 18'h0_0000;
        host_oe = 1'b0;
        sel_n = 2'h3;
        #7;
        forever
        begin
            #200;
            k = ~k;
            k_n = ~k_n;
        end
    end

    // command at one k rise
    // Pins change mid half-period, so they stand two clk each side of an edge
    task automatic cmd(input logic rd, input ddrb_addr_t a);
        @(posedge k);
        #100;
        load_n = 1'b0;
        rd_wr = rd;
        addr = a;
        @(posedge k);
        #100;
        load_n = 1'b1;
        addr = ~a;
    endtask

    // word0 at next k rise, word1 at next k_n rise
    task automatic write(input ddrb_addr_t a, input ddrb_word_t w0, input ddrb_word_t w1,
                         input ddrb_be_t s0, input ddrb_be_t s1);
        cmd(1'b0, a);
        host_oe = 1'b1;
        dq_drv = w0;
        sel_n = s0;
        @(posedge k);
        #100;
        dq_drv = w1;
        sel_n = s1;
        @(posedge k_n);
        #100;
        // Released line floats: show the inverse, not a held value
        host_oe = 1'b0;
        dq_drv = ~w1;
        sel_n = 2'h3;
    endtask

    // capture runs well past the burst, so writes follow idle cycles
    // Slot s is sampled late in the half period after half-edge s
    task automatic read(input ddrb_addr_t a, output logic [7:0] oe_v,
                        output logic [7:0] vld_v, output logic [7:0] ec_v,
                        output logic [7:0] ecn_v, output ddrb_word_t q[8]);
        cmd(1'b1, a);
        #190;
        for (int s = 0; s < 8; s++)
        begin
            oe_v[s] = dq_oe;
            vld_v[s] = read_valid_flag;
            ec_v[s] = echo_clock;
            ecn_v[s] = echo_clock_n;
            q[s] = dq_out;
            #200;
        end
    endtask
endmodule

`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the double-rate SRAM port
`timescale 1ns/100ps
`default_nettype none

module testbench
    import ddrb_pkg::*;
    ;
    logic       clk;
    logic       srst;
    logic       ce;
    logic       pll_off_n;
    logic       k;
    logic       k_n;
    logic       load_n;
    logic       rd_wr;
    ddrb_addr_t addr;
    ddrb_word_t dq_drv;
    ddrb_word_t dq_in;
    ddrb_word_t dq_out;
    logic       dq_oe;
    logic       host_oe;
    ddrb_be_t   sel_n;
    logic       echo_clock;
    logic       echo_clock_n;
    logic       read_valid_flag;
    int         error_cnt = 0;
    int         checked = 0;

    // Shared data pins: the port drives when dq_oe is set, the host otherwise
    assign dq_in = dq_oe ? dq_out : dq_drv;

    ddrb_port dut (
        .clk, .srst, .ce, .k, .k_n, .load_n, .rd_wr, .addr, .dq_in, .dq_out, .dq_oe,
        .byte_write_sel_n(sel_n), .pll_off_n, .echo_clock, .echo_clock_n, .read_valid_flag
    );

    ddrb_host_model host (
        .k, .k_n, .load_n, .rd_wr, .addr, .dq_drv, .host_oe, .sel_n,
        .dq_out, .dq_oe, .read_valid_flag, .echo_clock, .echo_clock_n
    );

    // 20 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever
        begin
            #25;
            clk = ~clk;
        end
    end

    // Automatic, since the contention monitor may call it at the same time
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read one line and judge drive window, flag, echo phase and both words
    task automatic check_read(input ddrb_addr_t a, input int lat, input ddrb_word_t w0,
                              input ddrb_word_t w1);
        logic [7:0] oe_v;
        logic [7:0] vld_v;
        logic [7:0] ec_v;
        logic [7:0] ecn_v;
        ddrb_word_t q[8];
        host.read(a, oe_v, vld_v, ec_v, ecn_v, q);
        chk(oe_v, 8'h03 << lat, "read drive window");
        chk(vld_v, 8'h03 << (lat - 1), "read valid window");
        chk({ec_v, ecn_v}, 16'h55aa, "echo clock phase");
        chk(q[lat], w0, "first read word");
        chk(q[lat + 1], w1, "second read word");
    endtask

    task automatic test_reset();
        chk({dq_oe, read_valid_flag, echo_clock, echo_clock_n}, 4'h0, "reset outputs");
        chk(dq_out, 18'h0_0000, "reset data");
        $display("test reset done");
    endtask

    // Both latency modes, lowest and highest line, write then read back
    task automatic test_latency();
        ddrb_word_t w0;
        ddrb_addr_t a;
        for (int m = 0; m < 2; m++)
        begin
            for (int i = 0; i < 2; i++)
            begin
                w0 = 18'h2_ab0c ^ 18'(m * 3 + i);
                a = (i == 1) ? 4'hf : 4'h0;
                @(negedge clk);
                pll_off_n = m[0];
                host.write(a, w0, ~w0, 2'h0, 2'h0);
                check_read(a, (m == 1) ? 5 : 2, w0, ~w0);
            end
        end
        $display("test latency done");
    endtask

    // Full write, mixed selects, then all deasserted, then read back
    task automatic test_byte_sel();
        @(negedge clk);
        pll_off_n = 1'b0;
        host.write(4'h7, 18'h3_ffff, 18'h0_0000, 2'h0, 2'h0);
        host.write(4'h7, 18'h0_0000, 18'h1_5555, 2'h2, 2'h1);
        host.write(4'h7, 18'h1_2345, 18'h2_3456, 2'h3, 2'h3);
        check_read(4'h7, 2, 18'h3_fe00, 18'h1_5400);
        $display("test byte select done");
    endtask

    // never both ends on the bus; sampled away from the launching edge
    always @(negedge clk)
    begin
        if (!srst)
        begin
            chk(host_oe & dq_oe, 1'b0, "bus contention");
        end
    end

    // Main sequence; inputs change on falling clk
    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        pll_off_n = 1'b0;
        repeat (20) @(negedge clk);
        test_reset();
        srst = 1'b0;
        repeat (4) @(negedge clk);
        test_latency();
        test_byte_sel();
        print_verdict();
    end

    // Hang guard, far beyond the expected run length
    initial
    begin
        #200000;
        error_cnt++;
        $display("wrong value at %0t ns: run timed out", $time);
        print_verdict();
    end
endmodule

`default_nettype wire
